// File: rtl/svr_pkg.sv
// constants and types for the servo input signal routing block
// assumes one 250 MHz clock and a plain word-indexed register port
package svr_pkg;

  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // register indices
  localparam logic [ADDR_W-1:0] REG_IN_SEL_A = 4'h0;
  localparam logic [ADDR_W-1:0] REG_IN_SEL_B = 4'h1;
  localparam logic [ADDR_W-1:0] REG_OUT_SEL  = 4'h2;
  localparam logic [ADDR_W-1:0] REG_OUT_POL  = 4'h3;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h4;

  // terminals and functions
  localparam int N_PIN   = 7;
  localparam int N_FUNC  = 8;
  localparam int N_GOUT  = 3;
  localparam int N_OFUNC = 9;
  localparam int SEL_W   = 4;
  localparam int OSEL_W  = 2;

  // function index order in the routed vector
  localparam int F_FWD_TRAVEL = 0;
  localparam int F_REV_TRAVEL = 1;
  localparam int F_FWD_CLAMP  = 2;
  localparam int F_REV_CLAMP  = 3;
  localparam int F_SLOWDOWN   = 4;
  localparam int F_LATCH1     = 5;
  localparam int N_LATCH      = 3;

  // selector codes
  localparam logic [SEL_W-1:0] SEL_PIN_LAST  = 4'h6;
  localparam logic [SEL_W-1:0] SEL_FORCE_ON  = 4'h7;
  localparam logic [SEL_W-1:0] SEL_FORCE_OFF = 4'h8;
  localparam logic [SEL_W-1:0] SEL_INV_FIRST = 4'h9;
  localparam logic [SEL_W-1:0] SEL_LATCH_LO  = 4'h4;
  localparam logic [SEL_W-1:0] SEL_LATCH_HI  = 4'hd;

  // selector reset values, lowest function in the lowest nibble
  localparam logic [DATA_W-1:0] IN_SEL_A_RST = 32'h0000_8821;
  localparam logic [DATA_W-1:0] IN_SEL_B_RST = 32'h0000_6543;
  localparam logic [DATA_W-1:0] OUT_SEL_RST  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] OUT_POL_RST  = 32'h0000_0000;

  // status field positions
  localparam int ST_FUNC_LSB  = 0;
  localparam int ST_BB_BIT    = 8;
  localparam int ST_MON_BIT   = 9;
  localparam int ST_INV_LSB   = 10;
  localparam int ST_PIN_LSB   = 16;
  localparam int ST_CUTA_BIT  = 23;
  localparam int ST_CUTB_BIT  = 24;
  localparam int ST_GOUT_LSB  = 25;

  typedef struct packed {
    logic latch_trigger_3;
    logic latch_trigger_2;
    logic latch_trigger_1;
    logic homing_slowdown_switch;
    logic reverse_torque_clamp;
    logic forward_torque_clamp;
    logic reverse_travel_block;
    logic forward_travel_block;
  } svr_func_t;

endpackage : svr_pkg

// File: rtl/svr_fn_pick.sv
// one input function picked from the terminals by a 4-bit selector
// assumes terminal levels are already synchronous, 1 = terminal on
module svr_fn_pick
  import svr_pkg::*;
#(
  parameter bit LATCH_ONLY = 1'b0
) (
  input  wire logic [svr_pkg::SEL_W-1:0] i_sel,
  input  wire logic [svr_pkg::N_PIN-1:0] i_pins,
  output logic                           o_level,
  output logic                           o_invalid
);

  function automatic logic latch_code_ok(input logic [SEL_W-1:0] s);
    latch_code_ok = (s >= SEL_LATCH_LO && s <= SEL_PIN_LAST) ||
                    (s >= SEL_LATCH_HI);
  endfunction : latch_code_ok

  logic [SEL_W-1:0] inv_idx;

  always_comb begin
    inv_idx   = i_sel - SEL_INV_FIRST;
    o_invalid = 1'b0;
    o_level   = 1'b0;
    if (LATCH_ONLY && !latch_code_ok(i_sel) &&
        i_sel != SEL_FORCE_ON && i_sel != SEL_FORCE_OFF) begin
      o_invalid = 1'b1;
    end else if (i_sel <= SEL_PIN_LAST) begin
      o_level = i_pins[i_sel[2:0]];
    end else if (i_sel == SEL_FORCE_ON) begin
      o_level = 1'b1;
    end else if (i_sel == SEL_FORCE_OFF) begin
      o_level = 1'b0;
    end else begin
      o_level = ~i_pins[inv_idx[2:0]];
    end
  end

endmodule : svr_fn_pick

// File: rtl/svr_route.sv
// servo input signal routing: terminals to functions, safety cutoff,
// general output terminal allocation
// assumes synchronous inputs and a plain one-cycle register port
//
// Behaviour
// - either cutoff input off forces baseblock
// - monitor on only when both off and baseblocked
// - 4-bit selector: pin, forced on/off, inverted pin
// - shared terminal drives every mapped function
// - latch functions only from last three terminals
// - terminal allocation set by configuration registers
// - shared output terminal driven by OR
//
// Strobed register access and the placing of the registers were left to the implementer.
module svr_route
  import svr_pkg::*;
(
  input  wire logic                        i_clk,
  input  wire logic                        i_nrst,
  input  wire logic [svr_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [svr_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic                        i_we,
  input  wire logic                        i_re,
  output logic      [svr_pkg::DATA_W-1:0]  o_rdata,
  input  wire logic [svr_pkg::N_PIN-1:0]   i_seq_pins,
  input  wire logic                        i_cutoff_input_a,
  input  wire logic                        i_cutoff_input_b,
  input  wire logic                        i_drive_off_req,
  input  wire logic [svr_pkg::N_OFUNC-1:0] i_out_funcs,
  output svr_pkg::svr_func_t               o_funcs,
  output logic                             o_baseblock,
  output logic                             o_cutoff_monitor_output,
  output logic      [svr_pkg::N_GOUT-1:0]  o_general_output,
  output logic      [svr_pkg::N_LATCH-1:0] o_latch_invalid
);

  // configuration registers
  logic [DATA_W-1:0] in_sel_a_q;
  logic [DATA_W-1:0] in_sel_a_d;
  logic [DATA_W-1:0] in_sel_b_q;
  logic [DATA_W-1:0] in_sel_b_d;
  logic [DATA_W-1:0] out_sel_q;
  logic [DATA_W-1:0] out_sel_d;
  logic [DATA_W-1:0] out_pol_q;
  logic [DATA_W-1:0] out_pol_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // routed state
  logic [N_FUNC-1:0]  func_q;
  logic [N_FUNC-1:0]  func_d;
  logic               bb_q;
  logic               bb_d;
  logic               mon_q;
  logic               mon_d;
  logic [N_GOUT-1:0]  gout_q;
  logic [N_GOUT-1:0]  gout_d;
  logic [N_LATCH-1:0] linv_q;
  logic [N_LATCH-1:0] linv_d;

  // combinational picks
  logic [N_FUNC-1:0]             pick_level;
  logic [N_FUNC-1:0]             pick_inv;
  logic [N_FUNC*SEL_W-1:0]       sel_all;

  assign sel_all = {in_sel_b_q[N_FUNC*SEL_W/2-1:0],
                    in_sel_a_q[N_FUNC*SEL_W/2-1:0]};

  // one selector per input function, shared terminals fan out freely
  genvar g;
  generate
    for (g = 0; g < N_FUNC; g++) begin : g_pick
      svr_fn_pick #(
        .LATCH_ONLY ((g >= F_LATCH1) ? 1'b1 : 1'b0)
      ) u_pick (
        .i_sel     (sel_all[g*SEL_W +: SEL_W]),
        .i_pins    (i_seq_pins),
        .o_level   (pick_level[g]),
        .o_invalid (pick_inv[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  function automatic logic [DATA_W-1:0] status_word(
    input logic [N_FUNC-1:0]  f,
    input logic               bb,
    input logic               mon,
    input logic [N_LATCH-1:0] linv,
    input logic [N_PIN-1:0]   pins,
    input logic               ca,
    input logic               cb,
    input logic [N_GOUT-1:0]  go
  );
    logic [DATA_W-1:0] w;
    w = '0;
    w[ST_FUNC_LSB +: N_FUNC]  = f;
    w[ST_BB_BIT]              = bb;
    w[ST_MON_BIT]             = mon;
    w[ST_INV_LSB +: N_LATCH]  = linv;
    w[ST_PIN_LSB +: N_PIN]    = pins;
    w[ST_CUTA_BIT]            = ca;
    w[ST_CUTB_BIT]            = cb;
    w[ST_GOUT_LSB +: N_GOUT]  = go;
    status_word = w;
  endfunction : status_word

  localparam int SEL_BITS  = N_FUNC * SEL_W / 2;
  localparam int OSEL_BITS = N_OFUNC * OSEL_W;

  always_comb begin
    in_sel_a_d = in_sel_a_q;
    in_sel_b_d = in_sel_b_q;
    out_sel_d  = out_sel_q;
    out_pol_d  = out_pol_q;
    rdata_d    = '0;
    if (i_we) begin
      case (i_addr)
        REG_IN_SEL_A: begin
          in_sel_a_d = '0;
          in_sel_a_d[SEL_BITS-1:0] = i_wdata[SEL_BITS-1:0];
        end
        REG_IN_SEL_B: begin
          in_sel_b_d = '0;
          in_sel_b_d[SEL_BITS-1:0] = i_wdata[SEL_BITS-1:0];
        end
        REG_OUT_SEL: begin
          out_sel_d = '0;
          out_sel_d[OSEL_BITS-1:0] = i_wdata[OSEL_BITS-1:0];
        end
        REG_OUT_POL: begin
          out_pol_d = '0;
          out_pol_d[N_GOUT-1:0] = i_wdata[N_GOUT-1:0];
        end
        default: begin
        end
      endcase
    end
    if (i_re) begin
      case (i_addr)
        REG_IN_SEL_A: rdata_d = in_sel_a_q;
        REG_IN_SEL_B: rdata_d = in_sel_b_q;
        REG_OUT_SEL:  rdata_d = out_sel_q;
        REG_OUT_POL:  rdata_d = out_pol_q;
        REG_STATUS:   rdata_d = status_word(func_q, bb_q, mon_q, linv_q,
                                            i_seq_pins, i_cutoff_input_a,
                                            i_cutoff_input_b, gout_q);
        default:      rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      in_sel_a_q <= IN_SEL_A_RST;
      in_sel_b_q <= IN_SEL_B_RST;
      out_sel_q  <= OUT_SEL_RST;
      out_pol_q  <= OUT_POL_RST;
      rdata_q    <= '0;
    end else begin
      in_sel_a_q <= in_sel_a_d;
      in_sel_b_q <= in_sel_b_d;
      out_sel_q  <= out_sel_d;
      out_pol_q  <= out_pol_d;
      rdata_q    <= rdata_d;
    end
  end

  // ------------------------------------------------------------
  // input functions and safety cutoff
  // ------------------------------------------------------------
  always_comb begin
    func_d = pick_level & ~pick_inv;
    linv_d = pick_inv[F_LATCH1 +: N_LATCH];
    // cutoff inputs are off when low; nothing else can hold the drive on
    bb_d   = ~i_cutoff_input_a | ~i_cutoff_input_b | i_drive_off_req;
    // monitor needs both channels off and the drive really blocked
    mon_d  = ~i_cutoff_input_a & ~i_cutoff_input_b & bb_q;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      func_q <= '0;
      linv_q <= '0;
      bb_q   <= 1'b1;
      mon_q  <= 1'b0;
    end else begin
      func_q <= func_d;
      linv_q <= linv_d;
      bb_q   <= bb_d;
      mon_q  <= mon_d;
    end
  end

  // ------------------------------------------------------------
  // general output terminals
  // ------------------------------------------------------------
  function automatic logic [N_GOUT-1:0] out_onehot(
    input logic [OSEL_W-1:0] s
  );
    logic [N_GOUT-1:0] v;
    v = '0;
    if (s != '0) begin
      v[s - 2'h1] = 1'b1;
    end
    out_onehot = v;
  endfunction : out_onehot

  always_comb begin
    logic [N_GOUT-1:0] acc;
    acc = '0;
    for (int k = 0; k < N_OFUNC; k++) begin
      if (i_out_funcs[k]) begin
        acc = acc | out_onehot(out_sel_q[k*OSEL_W +: OSEL_W]);
      end
    end
    gout_d = acc ^ out_pol_q[N_GOUT-1:0];
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gout_q <= '0;
    end else begin
      gout_q <= gout_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_rdata                 = rdata_q;
  assign o_funcs                 = svr_func_t'(func_q);
  assign o_baseblock             = bb_q;
  assign o_cutoff_monitor_output = mon_q;
  assign o_general_output        = gout_q;
  assign o_latch_invalid         = linv_q;

endmodule : svr_route

// File: sim/svr_host_model.sv
// host controller sequence outputs and safety device
// assumes commands from the bench; levels change one edge later
module svr_host_model
  import svr_pkg::*;
(
  input  wire logic                      i_clk,
  input  wire logic [svr_pkg::N_PIN-1:0] i_pins_cmd,
  input  wire logic [1:0]                i_cut_cmd,
  output logic      [svr_pkg::N_PIN-1:0] o_seq_pins,
  output logic                           o_cut_a,
  output logic                           o_cut_b
);
  always_ff @(posedge i_clk) begin
    o_seq_pins <= i_pins_cmd;
    o_cut_a    <= i_cut_cmd[0];
    o_cut_b    <= i_cut_cmd[1];
  end
endmodule : svr_host_model

// File: sim/svr_route_props.sv
// checker for the routing block, bound to its ports
// assumes the register port timing of the package
module svr_route_props
  import svr_pkg::*;
(
  input wire logic                        i_clk,
  input wire logic                        i_nrst,
  input wire logic [svr_pkg::ADDR_W-1:0]  i_addr,
  input wire logic [svr_pkg::DATA_W-1:0]  i_wdata,
  input wire logic                        i_we,
  input wire logic                        i_re,
  input wire logic [svr_pkg::DATA_W-1:0]  o_rdata,
  input wire logic                        i_cutoff_input_a,
  input wire logic                        i_cutoff_input_b,
  input wire svr_pkg::svr_func_t          o_funcs,
  input wire logic                        o_baseblock,
  input wire logic                        o_cutoff_monitor_output,
  input wire logic [svr_pkg::N_GOUT-1:0]  o_general_output,
  input wire logic [svr_pkg::N_LATCH-1:0] o_latch_invalid
);
  logic [15:0] sa_q;
  // shadow of the first selector word
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sa_q <= IN_SEL_A_RST[15:0];
    end else if (i_we && i_addr == REG_IN_SEL_A) begin
      sa_q <= i_wdata[15:0];
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_cut_forces_bb: assert property (!(i_cutoff_input_a && i_cutoff_input_b) |=> o_baseblock)
    else $error("baseblock missing during cutoff");
  a_mon_turns_on: assert property (!i_cutoff_input_a && !i_cutoff_input_b && o_baseblock
    |=> o_cutoff_monitor_output)
    else $error("monitor not on");
  a_mon_has_cause: assert property (o_cutoff_monitor_output
    |-> $past(!i_cutoff_input_a && !i_cutoff_input_b && o_baseblock))
    else $error("monitor on without cause");
  a_forced_sel: assert property ($past(sa_q[11:8]) inside {4'h7, 4'h8}
    |-> o_funcs.forward_torque_clamp == ($past(sa_q[11:8]) == 4'h7))
    else $error("forced selector ignored");
  a_shared_pin: assert property ($past(sa_q[3:0] == sa_q[7:4])
    |-> o_funcs.forward_travel_block == o_funcs.reverse_travel_block)
    else $error("shared terminal differs");
  a_latch_excl: assert property ((o_latch_invalid & o_funcs[7:5]) == 3'h0)
    else $error("invalid latch active");
  a_rdata_idle: assert property (!$past(i_re) |-> o_rdata == 32'h0)
    else $error("read data outside read");
  a_status_bb: assert property ($past(i_re && i_addr == REG_STATUS) && $stable(o_baseblock)
    |-> o_rdata[ST_BB_BIT] == o_baseblock)
    else $error("status baseblock wrong");
  c_mon: cover property (o_cutoff_monitor_output);
  c_latch_bad: cover property (|o_latch_invalid);
  c_gout: cover property (|o_general_output);
endmodule : svr_route_props

bind svr_route svr_route_props u_props (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re),
  .o_rdata(o_rdata), .i_cutoff_input_a(i_cutoff_input_a), .i_cutoff_input_b(i_cutoff_input_b),
  .o_funcs(o_funcs), .o_baseblock(o_baseblock), .o_cutoff_monitor_output(o_cutoff_monitor_output),
  .o_general_output(o_general_output), .o_latch_invalid(o_latch_invalid)
);

// File: sim/test_servo_input_signal_routing.sv
// self-checking bench for the routing block
// assumes the host model drives terminals and safety channels
module test_servo_input_signal_routing;
  timeunit 1ns;
  timeprecision 1ps;
  import svr_pkg::*;
  logic i_clk, i_nrst, i_we, i_re, i_drive_off_req, cut_a, cut_b, lv;
  logic [ADDR_W-1:0]  i_addr;
  logic [DATA_W-1:0]  i_wdata, o_rdata;
  logic [N_PIN-1:0]   pins_cmd, seq_pins, p;
  logic [1:0]         cut_cmd;
  logic [N_OFUNC-1:0] i_out_funcs;
  logic [3:0]         c;
  svr_func_t          o_funcs;
  logic o_baseblock, o_cutoff_monitor_output;
  logic [N_GOUT-1:0]  o_general_output;
  logic [N_LATCH-1:0] o_latch_invalid;
  int num_errors = 0;
  int compares = 0;
  svr_host_model u_host (.i_clk(i_clk), .i_pins_cmd(pins_cmd), .i_cut_cmd(cut_cmd),
    .o_seq_pins(seq_pins), .o_cut_a(cut_a), .o_cut_b(cut_b));
  svr_route u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
    .i_re(i_re), .o_rdata(o_rdata), .i_seq_pins(seq_pins), .i_cutoff_input_a(cut_a),
    .i_cutoff_input_b(cut_b), .i_drive_off_req(i_drive_off_req), .i_out_funcs(i_out_funcs),
    .o_funcs(o_funcs), .o_baseblock(o_baseblock), .o_cutoff_monitor_output(o_cutoff_monitor_output),
    .o_general_output(o_general_output), .o_latch_invalid(o_latch_invalid));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_we <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_re <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_re <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask : rd
  // model and routing latency is three edges at most
  task automatic settle;
    repeat (4) @(posedge i_clk);
    #1;
  endtask : settle
  function automatic logic fexp(input logic [3:0] s, input logic [6:0] v);
    if (s < 4'h7) return v[s[2:0]];
    if (s == 4'h7) return 1'b1;
    if (s == 4'h8) return 1'b0;
    return !v[3'(s - 4'h9)];
  endfunction : fexp
  task automatic stop_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (5000) @(posedge i_clk);
    num_errors++;
    stop_test;
  end
  initial begin
    i_nrst = 1'b0; i_we = 1'b0; i_re = 1'b0; i_addr = '0; i_wdata = '0;
    i_drive_off_req = 1'b0; i_out_funcs = '0; pins_cmd = '0; cut_cmd = 2'b11;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(REG_IN_SEL_A, IN_SEL_A_RST);
    rd(REG_IN_SEL_B, IN_SEL_B_RST);
    rd(4'h9, 32'h0);
    cut_cmd <= 2'b10;
    settle;
    chk(32'(o_baseblock), 32'h1);
    chk(32'(o_cutoff_monitor_output), 32'h0);
    @(posedge i_clk);
    cut_cmd <= 2'b00;
    settle;
    chk(32'(o_cutoff_monitor_output), 32'h1);
    wr(REG_STATUS, 32'hffff_ffff);
    rd(REG_STATUS, 32'h0000_0300);
    cut_cmd <= 2'b11;
    i_drive_off_req <= 1'b1;
    settle;
    chk(32'({o_cutoff_monitor_output, o_baseblock}), 32'h1);
    @(posedge i_clk);
    i_drive_off_req <= 1'b0;
    settle;
    chk(32'(o_baseblock), 32'h0);
    for (int i = 0; i < 32; i++) begin
      c = i[3:0];
      p = i[4] ? 7'h2a : 7'h55;
      @(posedge i_clk);
      pins_cmd <= p;
      wr(REG_IN_SEL_A, {16'h0, 4'h0, c, 4'h2, 4'h2});
      settle;
      chk(32'(o_funcs.forward_torque_clamp), 32'(fexp(c, p)));
      chk(32'({o_funcs.reverse_travel_block, o_funcs.forward_travel_block}), {30'h0, {2{p[2]}}});
      wr(REG_IN_SEL_B, {16'h0, 4'h6, 4'h5, c, 4'h8});
      settle;
      lv = c inside {[4'h4:4'h8], [4'hd:4'hf]};
      chk(32'(o_funcs.latch_trigger_1), 32'(lv & fexp(c, p)));
      chk(32'(o_latch_invalid[0]), 32'(!lv));
    end
    wr(REG_OUT_SEL, 32'h0002_0002);
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk);
      i_out_funcs <= (k == 0) ? 9'h001 : (k == 1) ? 9'h100 : 9'h000;
      settle;
      chk(32'(o_general_output), (k < 2) ? 32'h2 : 32'h0);
    end
    wr(REG_OUT_POL, 32'h2);
    settle;
    chk(32'(o_general_output), 32'h2);
    wr(REG_OUT_POL, 32'h0);
    wr(REG_OUT_SEL, 32'h0003_0001);
    @(posedge i_clk);
    i_out_funcs <= 9'h101;
    settle;
    chk(32'(o_general_output), 32'h5);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk(32'({o_general_output, o_cutoff_monitor_output, o_baseblock}), 32'h1);
    @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(REG_OUT_SEL, OUT_SEL_RST);
    settle;
    chk(32'(o_general_output), 32'h0);
    stop_test;
  end
endmodule : test_servo_input_signal_routing
